//--- rtl/branch_move_or_exec_pkg.sv
/*
  Constants for the branch / move / OR execution block: opcodes, field
  positions, status bit positions, reset values and state codes.
  Assumes a 12-bit instruction word and an 8-bit data path.
*/
package branch_move_or_exec_pkg;

  localparam int INSTR_W = 12;
  localparam int DATA_W = 8;
  localparam int PC_W = 11;
  localparam int FADDR_W = 5;

  // Opcode patterns and the bits that each pattern compares
  localparam logic [11:0] OPC_NOP = 12'h000;
  localparam logic [11:0] OPC_OPTION = 12'h002;
  localparam logic [11:0] MSK_FULL = 12'hFFF;
  localparam logic [11:0] OPC_MOVE_ACC_TO_FILE = 12'h020;
  localparam logic [11:0] MSK_MOVE_ACC_TO_FILE = 12'hFE0;
  localparam logic [11:0] OPC_OR_ACC_WITH_FILE = 12'h100;
  localparam logic [11:0] OPC_MOVE_FILE = 12'h200;
  localparam logic [11:0] MSK_FILE_D = 12'hFC0;
  localparam logic [11:0] OPC_ABSOLUTE_BRANCH = 12'hA00;
  localparam logic [11:0] MSK_ABSOLUTE_BRANCH = 12'hE00;
  localparam logic [11:0] OPC_LOAD_LITERAL_ACC = 12'hC00;
  localparam logic [11:0] OPC_OR_LITERAL_INTO_ACC = 12'hD00;
  localparam logic [11:0] MSK_LITERAL = 12'hF00;

  // Instruction fields
  localparam int DEST_BIT = 5;
  localparam int BRANCH_K_MSB = 8;
  localparam int LIT_MSB = 7;
  localparam int FADDR_MSB = 4;

  // Status register layout and its file address
  localparam logic [4:0] STATUS_ADDR = 5'h03;
  localparam int STATUS_Z_BIT = 2;
  localparam int STATUS_PAGE_LSB = 5;
  localparam int STATUS_PAGE_MSB = 6;

  // Reset values
  localparam logic [10:0] PC_RST = 11'h000;
  localparam logic [7:0] ACC_RST = 8'h00;
  localparam logic [7:0] STATUS_RST = 8'h18;
  localparam logic [7:0] OPTION_RST = 8'hFF;

  // Two clocks per instruction cycle: decode, then execute
  localparam int CLKS_PER_ICYCLE = 2;

  typedef enum logic [1:0] {
    ST_DECODE = 2'b00,
    ST_EXECUTE = 2'b01,
    ST_FLUSH_D = 2'b10,
    ST_FLUSH_E = 2'b11
  } exec_state_e;

  typedef enum logic [3:0] {
    OP_NOP = 4'b0000,
    OP_ABSOLUTE_BRANCH = 4'b0001,
    OP_OR_LITERAL_INTO_ACC = 4'b0010,
    OP_OR_ACC_WITH_FILE = 4'b0011,
    OP_MOVE_ACC_TO_FILE = 4'b0100,
    OP_MOVE_FILE = 4'b0101,
    OP_LOAD_LITERAL_ACC = 4'b0110,
    OP_OPTION = 4'b0111,
    OP_OTHER = 4'b1000
  } op_e;

endpackage

//--- rtl/file_reg_mem.sv
/*
  General purpose file register storage, 32 words of 8 bits.
  Read data come out of a register one clock after the address.
  Assumes the caller never reads and writes the same word in one clock.
*/
module file_reg_mem
  import branch_move_or_exec_pkg::*;
(
  input wire logic ref_clk_in,
  input wire logic [FADDR_W-1:0] rd_addr_in,
  output logic [DATA_W-1:0] rd_data_out,
  input wire logic wr_en_in,
  input wire logic [FADDR_W-1:0] wr_addr_in,
  input wire logic [DATA_W-1:0] wr_data_in
);

  logic [DATA_W-1:0] mem_r [0:(1<<FADDR_W)-1];
  logic [DATA_W-1:0] rd_data_r;

  // No reset: contents are undefined until software writes them
  always_ff @(posedge ref_clk_in)
  begin
    if (wr_en_in)
    begin
      mem_r[wr_addr_in] <= wr_data_in;
    end
  end

  always_ff @(posedge ref_clk_in)
  begin
    rd_data_r <= mem_r[rd_addr_in];
  end

  assign rd_data_out = rd_data_r;

endmodule

//--- rtl/branch_move_or_exec.sv
/*
  Execution core for the branch, OR, move, literal and option group.
  Assumes instr_in holds the word at pc_out whenever fetch_out is high,
  and that one instruction cycle is two clocks of ref_clk_in.
*/
module branch_move_or_exec
  import branch_move_or_exec_pkg::*;
(
  input wire logic ref_clk_in,
  input wire logic sys_rst_in,
  input wire logic [INSTR_W-1:0] instr_in,
  output logic fetch_out,
  output logic [PC_W-1:0] pc_out,
  output logic [DATA_W-1:0] acc_out,
  output logic [DATA_W-1:0] status_out,
  output logic [DATA_W-1:0] option_out
);

  function automatic op_e decode_op(input logic [INSTR_W-1:0] w);
    op_e op;
    op = OP_OTHER;
    if ((w & MSK_FULL) == OPC_NOP)
      op = OP_NOP;
    else if ((w & MSK_FULL) == OPC_OPTION)
      op = OP_OPTION;
    else if ((w & MSK_MOVE_ACC_TO_FILE) == OPC_MOVE_ACC_TO_FILE)
      op = OP_MOVE_ACC_TO_FILE;
    else if ((w & MSK_FILE_D) == OPC_OR_ACC_WITH_FILE)
      op = OP_OR_ACC_WITH_FILE;
    else if ((w & MSK_FILE_D) == OPC_MOVE_FILE)
      op = OP_MOVE_FILE;
    else if ((w & MSK_ABSOLUTE_BRANCH) == OPC_ABSOLUTE_BRANCH)
      op = OP_ABSOLUTE_BRANCH;
    else if ((w & MSK_LITERAL) == OPC_LOAD_LITERAL_ACC)
      op = OP_LOAD_LITERAL_ACC;
    else if ((w & MSK_LITERAL) == OPC_OR_LITERAL_INTO_ACC)
      op = OP_OR_LITERAL_INTO_ACC;
    return op;
  endfunction

  // Zero flag follows the result; other status bits pass through
  function automatic logic [DATA_W-1:0] with_zero(input logic [DATA_W-1:0] st,
                                                  input logic [DATA_W-1:0] val);
    logic [DATA_W-1:0] res;
    res = st;
    res[STATUS_Z_BIT] = (val == '0);
    return res;
  endfunction

  exec_state_e state_r;
  exec_state_e state_nxt;
  logic [INSTR_W-1:0] instr_r;
  logic [PC_W-1:0] pc_r;
  logic [PC_W-1:0] pc_nxt;
  logic [DATA_W-1:0] acc_r;
  logic [DATA_W-1:0] acc_nxt;
  logic [DATA_W-1:0] status_r;
  logic [DATA_W-1:0] status_nxt;
  logic [DATA_W-1:0] option_r;
  logic [DATA_W-1:0] option_nxt;
  logic fetch_r;
  op_e op;
  logic dest_file;
  logic [FADDR_W-1:0] faddr;
  logic [DATA_W-1:0] literal;
  logic [DATA_W-1:0] mem_rd;
  logic [DATA_W-1:0] fval;
  logic file_wr_en;
  logic [DATA_W-1:0] file_wr_data;
  logic mem_wr_en;

  assign op = decode_op(instr_r);
  assign dest_file = instr_r[DEST_BIT];
  assign faddr = instr_r[FADDR_MSB:0];
  assign literal = instr_r[LIT_MSB:0];
  // Status lives outside the memory so its page bits are always at hand
  assign fval = (faddr == STATUS_ADDR) ? status_r : mem_rd;
  assign mem_wr_en = file_wr_en && (faddr != STATUS_ADDR);

  file_reg_mem u_file_reg_mem (
    .ref_clk_in(ref_clk_in),
    .rd_addr_in(instr_in[FADDR_MSB:0]),
    .rd_data_out(mem_rd),
    .wr_en_in(mem_wr_en),
    .wr_addr_in(faddr),
    .wr_data_in(file_wr_data)
  );

  always_comb
  begin
    state_nxt = state_r;
    case (state_r)
      ST_DECODE: state_nxt = ST_EXECUTE;
      ST_EXECUTE: state_nxt = (op == OP_ABSOLUTE_BRANCH) ? ST_FLUSH_D : ST_DECODE;
      ST_FLUSH_D: state_nxt = ST_FLUSH_E;
      ST_FLUSH_E: state_nxt = ST_DECODE;
      default: state_nxt = ST_DECODE;
    endcase
  end

  always_comb
  begin
    pc_nxt = pc_r;
    acc_nxt = acc_r;
    status_nxt = status_r;
    option_nxt = option_r;
    file_wr_en = 1'b0;
    file_wr_data = acc_r;
    if (state_r == ST_EXECUTE)
    begin
      pc_nxt = pc_r + PC_W'(1);
      case (op)
        OP_ABSOLUTE_BRANCH:
        begin
          pc_nxt[BRANCH_K_MSB:0] = instr_r[BRANCH_K_MSB:0];
          pc_nxt[PC_W-1:BRANCH_K_MSB+1] = status_r[STATUS_PAGE_MSB:STATUS_PAGE_LSB];
        end
        OP_OR_LITERAL_INTO_ACC:
        begin
          acc_nxt = acc_r | literal;
          status_nxt = with_zero(status_r, acc_r | literal);
        end
        OP_OR_ACC_WITH_FILE:
        begin
          file_wr_data = acc_r | fval;
          file_wr_en = dest_file;
          if (!dest_file)
            acc_nxt = acc_r | fval;
          status_nxt = with_zero(dest_file && faddr == STATUS_ADDR ? file_wr_data : status_r,
                                 file_wr_data);
        end
        OP_MOVE_ACC_TO_FILE:
        begin
          file_wr_en = 1'b1;
          file_wr_data = acc_r;
          if (faddr == STATUS_ADDR)
            status_nxt = acc_r;
        end
        OP_MOVE_FILE:
        begin
          file_wr_data = fval;
          file_wr_en = dest_file;
          if (!dest_file)
            acc_nxt = fval;
          status_nxt = with_zero(status_r, fval);
        end
        OP_LOAD_LITERAL_ACC: acc_nxt = literal;
        OP_OPTION: option_nxt = acc_r;
        default: pc_nxt = pc_r + PC_W'(1);
      endcase
    end
  end

  always_ff @(posedge ref_clk_in)
  begin
    if (sys_rst_in)
      state_r <= ST_DECODE;
    else
      state_r <= state_nxt;
  end

  // Fetch strobe is registered from state_nxt, so it is high in the same clock as ST_DECODE and instr_in lines up
  always_ff @(posedge ref_clk_in)
  begin
    if (sys_rst_in)
      fetch_r <= 1'b1;
    else
      fetch_r <= (state_nxt == ST_DECODE);
  end

  always_ff @(posedge ref_clk_in)
  begin
    if (sys_rst_in)
      instr_r <= OPC_NOP;
    else if (state_r == ST_DECODE)
      instr_r <= instr_in;
  end

  always_ff @(posedge ref_clk_in)
  begin
    if (sys_rst_in)
      pc_r <= PC_RST;
    else
      pc_r <= pc_nxt;
  end

  always_ff @(posedge ref_clk_in)
  begin
    if (sys_rst_in)
      acc_r <= ACC_RST;
    else
      acc_r <= acc_nxt;
  end

  always_ff @(posedge ref_clk_in)
  begin
    if (sys_rst_in)
      status_r <= STATUS_RST;
    else
      status_r <= status_nxt;
  end

  always_ff @(posedge ref_clk_in)
  begin
    if (sys_rst_in)
      option_r <= OPTION_RST;
    else
      option_r <= option_nxt;
  end

  assign fetch_out = fetch_r;
  assign pc_out = pc_r;
  assign acc_out = acc_r;
  assign status_out = status_r;
  assign option_out = option_r;

  AST_BRANCH_LOW: assert property (@(posedge ref_clk_in) disable iff (sys_rst_in)
    (state_r == ST_EXECUTE && op == OP_ABSOLUTE_BRANCH)
      |=> pc_r[BRANCH_K_MSB:0] == $past(instr_r[BRANCH_K_MSB:0]))
    else $error("Branch low target wrong");

  AST_BRANCH_PAGE: assert property (@(posedge ref_clk_in) disable iff (sys_rst_in)
    (state_r == ST_EXECUTE && op == OP_ABSOLUTE_BRANCH)
      |=> pc_r[PC_W-1:BRANCH_K_MSB+1] == $past(status_r[STATUS_PAGE_MSB:STATUS_PAGE_LSB]))
    else $error("Branch page bits wrong");

  AST_BRANCH_TWO: assert property (@(posedge ref_clk_in) disable iff (sys_rst_in)
    (state_r == ST_EXECUTE && op == OP_ABSOLUTE_BRANCH)
      |=> $stable(status_r) && state_r == ST_FLUSH_D ##1 state_r == ST_FLUSH_E
          ##1 state_r == ST_DECODE && $stable(pc_r))
    else $error("Branch not two cycles");

  AST_OR_LIT: assert property (@(posedge ref_clk_in) disable iff (sys_rst_in)
    (state_r == ST_EXECUTE && op == OP_OR_LITERAL_INTO_ACC)
      |=> acc_r == ($past(acc_r) | $past(literal)) && status_r[STATUS_Z_BIT] == (acc_r == '0))
    else $error("OR literal result wrong");

  AST_OR_FILE: assert property (@(posedge ref_clk_in) disable iff (sys_rst_in)
    (state_r == ST_EXECUTE && op == OP_OR_ACC_WITH_FILE)
      |-> file_wr_en == dest_file && file_wr_data == (acc_r | fval)
          ##1 acc_r == ($past(dest_file) ? $past(acc_r) : $past(file_wr_data)))
    else $error("OR file destination wrong");

  AST_ACC_TO_FILE: assert property (@(posedge ref_clk_in) disable iff (sys_rst_in)
    (state_r == ST_EXECUTE && op == OP_MOVE_ACC_TO_FILE && faddr != STATUS_ADDR)
      |-> mem_wr_en && file_wr_data == acc_r ##1 $stable(status_r))
    else $error("Accumulator to file wrong");

  AST_MOVE_FILE: assert property (@(posedge ref_clk_in) disable iff (sys_rst_in)
    (state_r == ST_EXECUTE && op == OP_MOVE_FILE && !dest_file)
      |=> acc_r == $past(fval))
    else $error("File move to accumulator wrong");

  AST_MOVE_ZERO: assert property (@(posedge ref_clk_in) disable iff (sys_rst_in)
    (state_r == ST_EXECUTE && op == OP_MOVE_FILE)
      |=> status_r[STATUS_Z_BIT] == ($past(fval) == '0))
    else $error("File move zero flag wrong");

  AST_LOAD_LIT: assert property (@(posedge ref_clk_in) disable iff (sys_rst_in)
    (state_r == ST_EXECUTE && op == OP_LOAD_LITERAL_ACC)
      |=> acc_r == $past(literal) && $stable(status_r))
    else $error("Literal load wrong");

  AST_OPTION: assert property (@(posedge ref_clk_in) disable iff (sys_rst_in)
    (state_r == ST_EXECUTE && op == OP_OPTION)
      |=> option_r == $past(acc_r) && $stable(status_r) && $stable(acc_r))
    else $error("Option load wrong");

  AST_NOP: assert property (@(posedge ref_clk_in) disable iff (sys_rst_in)
    (state_r == ST_EXECUTE && op == OP_NOP)
      |=> pc_r == $past(pc_r) + PC_W'(1) && $stable(acc_r) && $stable(status_r)
          && $stable(option_r) && state_r == ST_DECODE)
    else $error("No-operation changed state");

  AST_ONE_CYCLE: assert property (@(posedge ref_clk_in) disable iff (sys_rst_in)
    (state_r == ST_EXECUTE && op != OP_ABSOLUTE_BRANCH)
      |=> state_r == ST_DECODE && fetch_out)
    else $error("Instruction took more than one cycle");

endmodule

//--- verification/tb_branch_move_or_exec.sv
/*
  Self-checking bench for branch_move_or_exec: directed corners and a
  seeded random instruction stream, checked against a bench model.
  Assumes the package encodings and a two-clock instruction cycle.
*/
`define CHK(got, exp) \
  begin \
    n_tests++; \
    if ((got) !== (exp)) \
    begin \
      error_cnt++; \
      $display("mismatch at %0t got %h expected %h", $time, got, exp); \
    end \
  end

module tb_branch_move_or_exec import branch_move_or_exec_pkg::*;;
  timeunit 1ns;
  timeprecision 100ps;

  logic ref_clk_in;
  logic sys_rst_in;
  logic [INSTR_W-1:0] instr_in;
  logic fetch_out;
  logic [PC_W-1:0] pc_out;
  logic [DATA_W-1:0] acc_out;
  logic [DATA_W-1:0] status_out;
  logic [DATA_W-1:0] option_out;
  logic [PC_W-1:0] m_pc;
  logic [DATA_W-1:0] m_acc;
  logic [DATA_W-1:0] m_st;
  logic [DATA_W-1:0] m_opt;
  logic [DATA_W-1:0] m_mem [32];
  int error_cnt;
  int n_tests;
  int seed_val;

  branch_move_or_exec dut_u (
    .ref_clk_in(ref_clk_in),
    .sys_rst_in(sys_rst_in),
    .instr_in(instr_in),
    .fetch_out(fetch_out),
    .pc_out(pc_out),
    .acc_out(acc_out),
    .status_out(status_out),
    .option_out(option_out)
  );

  initial
  begin
    ref_clk_in = 1'b0;
    forever #12.5 ref_clk_in = ~ref_clk_in;
  end

  task automatic stop_test();
    $display("comparisons %0d mismatches %0d", n_tests, error_cnt);
    if (error_cnt == 0 && n_tests > 0)
    begin
      $display("ALL CHECKS OK");
    end
    else
    begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask

  // Status lives outside the plain memory
  function automatic logic [7:0] rd(input logic [4:0] f);
    return (f == STATUS_ADDR) ? m_st : m_mem[f];
  endfunction

  function automatic void wr(input logic [4:0] f, input logic [7:0] v);
    if (f == STATUS_ADDR)
      m_st = v;
    else
      m_mem[f] = v;
  endfunction

  function automatic void set_z(input logic [7:0] v);
    m_st[STATUS_Z_BIT] = (v == 8'h00);
  endfunction

  // Returns the expected clocks for the instruction
  function automatic int model(input logic [11:0] w);
    logic [7:0] r;
    logic [4:0] f;
    f = w[4:0];
    m_pc = m_pc + 11'h001;
    if (w == OPC_OPTION)
      m_opt = m_acc;
    else if ((w & MSK_MOVE_ACC_TO_FILE) == OPC_MOVE_ACC_TO_FILE)
      wr(f, m_acc);
    else if ((w & MSK_FILE_D) == OPC_OR_ACC_WITH_FILE || (w & MSK_FILE_D) == OPC_MOVE_FILE)
    begin
      r = ((w & MSK_FILE_D) == OPC_MOVE_FILE) ? rd(f) : (rd(f) | m_acc);
      if (w[DEST_BIT])
        wr(f, r);
      else
        m_acc = r;
      set_z(r);
    end
    else if ((w & MSK_ABSOLUTE_BRANCH) == OPC_ABSOLUTE_BRANCH)
    begin
      m_pc = {m_st[STATUS_PAGE_MSB:STATUS_PAGE_LSB], w[8:0]};
      return 2 * CLKS_PER_ICYCLE;
    end
    else if ((w & MSK_LITERAL) == OPC_LOAD_LITERAL_ACC)
      m_acc = w[7:0];
    else if ((w & MSK_LITERAL) == OPC_OR_LITERAL_INTO_ACC)
    begin
      m_acc = m_acc | w[7:0];
      set_z(m_acc);
    end
    return CLKS_PER_ICYCLE;
  endfunction

  function automatic logic [11:0] rand_instr();
    logic [4:0] f;
    logic [11:0] d;
    do
      f = 5'($urandom_range(0, 31));
    while (f == STATUS_ADDR);
    d = 12'($urandom_range(0, 1)) << DEST_BIT;
    case ($urandom_range(0, 7))
      0: return OPC_NOP;
      1: return OPC_OPTION;
      2: return OPC_MOVE_ACC_TO_FILE | 12'(f);
      3: return OPC_OR_ACC_WITH_FILE | d | 12'(f);
      4: return OPC_MOVE_FILE | d | 12'(f);
      5: return OPC_ABSOLUTE_BRANCH | 12'($urandom_range(0, 511));
      6: return OPC_LOAD_LITERAL_ACC | 12'($urandom_range(0, 255));
      default: return OPC_OR_LITERAL_INTO_ACC | 12'($urandom_range(0, 255));
    endcase
  endfunction

  task automatic check_state();
    `CHK(pc_out, m_pc)
    `CHK(acc_out, m_acc)
    `CHK(status_out, m_st)
    `CHK(option_out, m_opt)
  endtask

  task automatic do_reset(input int n);
    sys_rst_in = 1'b1;
    repeat (n) @(posedge ref_clk_in);
    #1;
    sys_rst_in = 1'b0;
    m_pc = PC_RST;
    m_acc = ACC_RST;
    m_st = STATUS_RST;
    m_opt = OPTION_RST;
    `CHK(fetch_out, 1'b1)
    check_state();
  endtask

  // Next word waits for a fetch edge; bus shows garbage meanwhile
  task automatic run(input logic [11:0] w);
    int cyc;
    int exp_cyc;
    cyc = 0;
    instr_in = w;
    do
    begin
      @(posedge ref_clk_in);
      #1;
      cyc++;
      if (fetch_out !== 1'b1)
        instr_in = ~w;
    end
    while (fetch_out !== 1'b1 && cyc < 16);
    if (cyc >= 16)
    begin
      error_cnt++;
      stop_test();
    end
    exp_cyc = model(w);
    `CHK(cyc, exp_cyc)
    check_state();
  endtask

  initial
  begin
    error_cnt = 0;
    n_tests = 0;
    instr_in = OPC_NOP;
    seed_val = $urandom(15754);
    do_reset(8);
    for (int f = 0; f < 32; f++)
    begin
      if (f != STATUS_ADDR)
      begin
        run(OPC_LOAD_LITERAL_ACC | 12'($urandom_range(0, 255)));
        run(OPC_MOVE_ACC_TO_FILE | 12'(f));
      end
    end
    run(OPC_NOP);
    run(12'hE55);
    run(12'hC00);
    run(12'hD00);
    run(12'hD80);
    // write-back acts as a zero test
    run(12'hC00);
    run(12'h025);
    run(12'hC33);
    run(12'h225);
    run(12'h205);
    run(12'h125);
    run(12'h105);
    run(12'h123);
    run(12'h203);
    run(12'hC5A);
    run(OPC_OPTION);
    // page bits 11 then wrap of the counter
    run(12'hC7B);
    run(12'h023);
    run(12'hA55);
    run(12'hBFF);
    run(OPC_NOP);
    repeat (300) run(rand_instr());
    // Reset in mid-run keeps memory, restarts core
    do_reset(2);
    repeat (60) run(rand_instr());
    stop_test();
  end

  initial
  begin
    #1000000;
    error_cnt++;
    stop_test();
  end
endmodule
